// ### rtl/sbd_dir_ack.sv
// direction select and acknowledge check control of a two-wire bus port
// assumes the bus engine drives its strobes from logic on this clock
// and the cpu reaches the registers over a 32-bit apb port
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/100ps
`include "sbd_params.svh"

// Contract
// - direction bit at position 4 resets to 0; 0 receive, 1 transmit
// - software writes 0 or 1 to select receive or transmit
// - arbitration loss as master clears the direction bit to receive
// - after arbitration clear, writing 1 works only after reading 0
// - slave first-frame read bit 1 sets transmit; clearing needs read of 1
// - slave receive with an addressing format follows first-frame read bit
// - direction writes during a frame wait until frame and acknowledge end
// - acknowledge check off: acknowledges ignored, status flag stays 0
// - acknowledge check bit 3 resets 0; on, a received 1 halts transfer
// - arbitration loss clears master select; writing 1 needs read of 0
module sbd_dir_ack (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_active,
  input  wire logic        arb_lost,
  input  wire logic        rw_strobe,
  input  wire logic        rw_bit,
  input  wire logic        ack_strobe,
  input  wire logic        ack_bit,
  input  wire logic        start_detect,
  output logic             direction_select,
  output logic             master_select,
  output logic             ack_check_enable,
  output logic             ack_status_flag,
  output logic             transfer_halt,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  function automatic logic addr_is(input sbd_pkg::sbd_addr_t a,
                                   input sbd_pkg::sbd_addr_t t);
    addr_is = (a == t);
  endfunction

  // one wait state: pready rises on the second access cycle
  wire logic apb_access = psel & penable;
  wire logic apb_done   = apb_access & pready;
  wire logic wr_done    = apb_done & pwrite;
  wire logic rd_done    = apb_done & ~pwrite;

  wire logic sel_ctrl   = addr_is(paddr, `SBD_ADDR_CTRL);
  wire logic sel_fmt    = addr_is(paddr, `SBD_ADDR_FMT);
  wire logic sel_stat   = addr_is(paddr, `SBD_ADDR_STAT);
  wire logic sel_istat  = addr_is(paddr, `SBD_ADDR_IRQ_STAT);
  wire logic sel_imask  = addr_is(paddr, `SBD_ADDR_IRQ_MASK);
  wire logic sel_any    = sel_ctrl | sel_fmt | sel_stat | sel_istat | sel_imask;

  wire logic wr_ctrl    = wr_done & sel_ctrl;
  wire logic wr_fmt     = wr_done & sel_fmt;
  wire logic wr_istat   = wr_done & sel_istat;
  wire logic wr_imask   = wr_done & sel_imask;
  wire logic rd_ctrl    = rd_done & sel_ctrl;

  // ----------------------------------------------------------------------
  // internal state
  // ----------------------------------------------------------------------
  logic              fmt_a;
  logic              fmt_b;
  logic              arb_dir_lock;
  logic              arb_dir_seen;
  logic              slv_dir_lock;
  logic              slv_dir_seen;
  logic              mst_lock;
  logic              mst_seen;
  logic              held_val;
  sbd_pkg::sbd_wr_e  wr_state;
  sbd_pkg::sbd_wr_e  next_wr_state;
  logic              next_dir;
  logic              next_mst;
  sbd_pkg::sbd_irq_t irq_status;
  sbd_pkg::sbd_irq_t irq_mask;
  sbd_pkg::sbd_irq_t irq_events;
  logic [7:0]        ctrl_byte;
  logic [7:0]        fmt_byte;
  logic [7:0]        stat_byte;

  // ----------------------------------------------------------------------
  // direction write acceptance
  // ----------------------------------------------------------------------
  wire logic wr_dir_val = pwdata[`SBD_BIT_DIR];
  // a write against a hardware change only lands once software has seen it
  wire logic dir_wr_ok  = wr_ctrl & (wr_dir_val ? (~arb_dir_lock | arb_dir_seen)
                                                : (~slv_dir_lock | slv_dir_seen));
  // slave receive with addressing format picks direction from first frame
  wire logic rw_take    = rw_strobe & ~master_select & ~direction_select
                          & (~fmt_a | ~fmt_b);
  wire logic hold_wr    = dir_wr_ok & frame_active;
  wire logic apply_now  = dir_wr_ok & ~frame_active;
  wire logic apply_held = (wr_state == sbd_pkg::SBD_WR_HELD) & ~frame_active;

  // hardware changes outrank software; a newer write beats a held one
  always_comb begin
    next_dir = direction_select;
    if (arb_lost) begin
      next_dir = 1'b0;
    end else if (rw_take) begin
      next_dir = rw_bit;
    end else if (apply_now) begin
      next_dir = wr_dir_val;
    end else if (apply_held) begin
      next_dir = held_val;
    end
  end

  // deferral state: a hardware change cancels a held write
  always_comb begin
    next_wr_state = wr_state;
    unique case (wr_state)
      sbd_pkg::SBD_WR_IDLE: begin
        if (hold_wr & ~arb_lost & ~rw_take) begin
          next_wr_state = sbd_pkg::SBD_WR_HELD;
        end
      end
      sbd_pkg::SBD_WR_HELD: begin
        if (arb_lost | rw_take | (~frame_active & ~hold_wr)) begin
          next_wr_state = sbd_pkg::SBD_WR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      direction_select <= `SBD_RST_DIR;
      wr_state         <= sbd_pkg::SBD_WR_IDLE;
      held_val         <= 1'b0;
    end else begin
      direction_select <= next_dir;
      wr_state         <= next_wr_state;
      if (hold_wr) begin
        held_val <= wr_dir_val;
      end
    end
  end

  // ----------------------------------------------------------------------
  // direction locks after hardware changes
  // ----------------------------------------------------------------------
  // the lock is set by hardware and wins over a release in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      arb_dir_lock <= 1'b0;
      arb_dir_seen <= 1'b0;
      slv_dir_lock <= 1'b0;
      slv_dir_seen <= 1'b0;
    end else begin
      if (arb_lost) begin
        arb_dir_lock <= 1'b1;
        arb_dir_seen <= 1'b0;
      end else if (dir_wr_ok & wr_dir_val) begin
        arb_dir_lock <= 1'b0;
        arb_dir_seen <= 1'b0;
      end else if (rd_ctrl & arb_dir_lock & ~direction_select) begin
        arb_dir_seen <= 1'b1;
      end
      if (rw_take & rw_bit) begin
        slv_dir_lock <= 1'b1;
        slv_dir_seen <= 1'b0;
      end else if (dir_wr_ok & ~wr_dir_val) begin
        slv_dir_lock <= 1'b0;
        slv_dir_seen <= 1'b0;
      end else if (rd_ctrl & slv_dir_lock & direction_select) begin
        slv_dir_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // master select
  // ----------------------------------------------------------------------
  wire logic mst_wr_val = pwdata[`SBD_BIT_MST];
  wire logic mst_wr_ok  = wr_ctrl & (~mst_wr_val | ~mst_lock | mst_seen);

  assign next_mst = arb_lost ? 1'b0 : (mst_wr_ok ? mst_wr_val : master_select);

  always_ff @(posedge clk) begin
    if (reset) begin
      master_select <= `SBD_RST_MST;
      mst_lock      <= 1'b0;
      mst_seen      <= 1'b0;
    end else begin
      master_select <= next_mst;
      if (arb_lost) begin
        mst_lock <= 1'b1;
        mst_seen <= 1'b0;
      end else if (mst_wr_ok & mst_wr_val) begin
        mst_lock <= 1'b0;
        mst_seen <= 1'b0;
      end else if (rd_ctrl & mst_lock & ~master_select) begin
        mst_seen <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // acknowledge check
  // ----------------------------------------------------------------------
  wire logic next_ack_check_enable = wr_ctrl ? pwdata[`SBD_BIT_ACK_CHECK_ENABLE] : ack_check_enable;
  wire logic ack_take  = ack_strobe & ack_check_enable;
  wire logic ack_err   = ack_take & ack_bit;

  // flag clears with the enable so it never shows a stale value while off
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_check_enable <= `SBD_RST_ACK_CHECK_ENABLE;
      ack_status_flag  <= 1'b0;
      transfer_halt    <= 1'b0;
    end else begin
      ack_check_enable <= next_ack_check_enable;
      if (~next_ack_check_enable) begin
        ack_status_flag <= 1'b0;
      end else if (ack_take) begin
        ack_status_flag <= ack_bit;
      end
      if (ack_err) begin
        transfer_halt <= 1'b1;
      end else if (start_detect | ~next_ack_check_enable) begin
        transfer_halt <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // format select
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      fmt_a <= `SBD_RST_FMT;
      fmt_b <= `SBD_RST_FMT;
    end else if (wr_fmt) begin
      fmt_a <= pwdata[`SBD_BIT_FMT_A];
      fmt_b <= pwdata[`SBD_BIT_FMT_B];
    end
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    irq_events                  = `SBD_RST_IRQ;
    irq_events[`SBD_IRQ_ARB]    = arb_lost;
    irq_events[`SBD_IRQ_ACK]    = ack_err;
    irq_events[`SBD_IRQ_SLV_TX] = rw_take & rw_bit;
  end

  sbd_sticky sbd_sticky_inst (
    .clk        (clk),
    .reset      (reset),
    .event_set  (irq_events),
    .clear_wr   (wr_istat),
    .clear_data (pwdata[`SBD_IRQ_W-1:0]),
    .mask_wr    (wr_imask),
    .mask_data  (pwdata[`SBD_IRQ_W-1:0]),
    .status     (irq_status),
    .mask       (irq_mask),
    .irq        (irq)
  );

  // ----------------------------------------------------------------------
  // read data and apb answer
  // ----------------------------------------------------------------------
  // reserved bits read as zero
  always_comb begin
    ctrl_byte                = 8'h00;
    ctrl_byte[`SBD_BIT_MST]  = master_select;
    ctrl_byte[`SBD_BIT_DIR]  = direction_select;
    ctrl_byte[`SBD_BIT_ACK_CHECK_ENABLE] = ack_check_enable;
    fmt_byte                 = 8'h00;
    fmt_byte[`SBD_BIT_FMT_A] = fmt_a;
    fmt_byte[`SBD_BIT_FMT_B] = fmt_b;
    stat_byte                = 8'h00;
    stat_byte[`SBD_BIT_ACKF] = ack_status_flag;
    stat_byte[`SBD_BIT_HALT] = transfer_halt;
  end

  wire logic [7:0]  irq_stat_byte = {5'h00, irq_status};
  wire logic [7:0]  irq_mask_byte = {5'h00, irq_mask};
  wire logic [7:0]  read_byte     = sel_ctrl  ? ctrl_byte :
                                    sel_fmt   ? fmt_byte :
                                    sel_stat  ? stat_byte :
                                    sel_istat ? irq_stat_byte :
                                    sel_imask ? irq_mask_byte : 8'h00;
  wire logic [31:0] read_word     = {24'h000000, read_byte};

  // data is latched on the same edge that raises pready so both appear together
  always_ff @(posedge clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_access & ~pready;
      if (apb_access & ~pready) begin
        prdata  <= pwrite ? 32'h00000000 : read_word;
        pslverr <= ~sel_any;
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_reset_dir;
    @(posedge clk) disable iff (reset)
    $past(reset) |-> (~direction_select & ~ack_check_enable);
  endproperty
  a_reset_dir: assert property (p_reset_dir)
    else $error("direction or ack check not cleared by reset");

  property p_arb_clear;
    @(posedge clk) disable iff (reset)
    arb_lost |=> (~direction_select & ~master_select);
  endproperty
  a_arb_clear: assert property (p_arb_clear)
    else $error("arbitration loss did not clear direction and master");

  property p_arb_block;
    @(posedge clk) disable iff (reset)
    (wr_ctrl & wr_dir_val & arb_dir_lock & ~arb_dir_seen & ~direction_select
     & ~rw_take & ~apply_held) |=> ~direction_select;
  endproperty
  a_arb_block: assert property (p_arb_block)
    else $error("direction set without reading it as zero");

  property p_slv_block;
    @(posedge clk) disable iff (reset)
    (wr_ctrl & ~wr_dir_val & slv_dir_lock & ~slv_dir_seen & direction_select
     & ~arb_lost & ~apply_held) |=> direction_select;
  endproperty
  a_slv_block: assert property (p_slv_block)
    else $error("direction cleared without reading it as one");

  property p_slave_rw;
    @(posedge clk) disable iff (reset)
    (rw_take & ~arb_lost) |=> (direction_select == $past(rw_bit));
  endproperty
  a_slave_rw: assert property (p_slave_rw)
    else $error("first frame read bit not applied to direction");

  property p_defer;
    @(posedge clk) disable iff (reset)
    (hold_wr & frame_active & ~arb_lost & ~rw_take & ~apply_held)
      |=> $stable(direction_select);
  endproperty
  a_defer: assert property (p_defer)
    else $error("direction changed during a frame");

  property p_apply;
    @(posedge clk) disable iff (reset)
    (apply_held & ~arb_lost & ~rw_take & ~apply_now)
      |=> (direction_select == $past(held_val)) && (wr_state == sbd_pkg::SBD_WR_IDLE);
  endproperty
  a_apply: assert property (p_apply)
    else $error("held direction write not applied after the frame");

  property p_ack_ignore;
    @(posedge clk) disable iff (reset)
    ~ack_check_enable |-> ~ack_status_flag;
  endproperty
  a_ack_ignore: assert property (p_ack_ignore)
    else $error("ack flag set while ack check is off");

  property p_ack_halt;
    @(posedge clk) disable iff (reset)
    (ack_check_enable & ack_strobe & ack_bit)
      |=> (transfer_halt & (ack_status_flag | ~ack_check_enable));
  endproperty
  a_ack_halt: assert property (p_ack_halt)
    else $error("negative acknowledge did not halt the transfer");

  property p_ack_pass;
    @(posedge clk) disable iff (reset)
    (ack_check_enable & ack_strobe & ~ack_bit) |=> ~ack_status_flag;
  endproperty
  a_ack_pass: assert property (p_ack_pass)
    else $error("positive acknowledge not captured into the flag");

  property p_mst_block;
    @(posedge clk) disable iff (reset)
    (wr_ctrl & mst_wr_val & mst_lock & ~mst_seen & ~arb_lost) |=> ~master_select;
  endproperty
  a_mst_block: assert property (p_mst_block)
    else $error("master set without reading it as zero");

endmodule

// ### rtl/sbd_params.svh
// constants of the serial bus direction and acknowledge control block
// assumes a 32-bit apb slave with byte addresses in the low eight bits
`ifndef SBD_PARAMS_SVH
`define SBD_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SBD_ADDR_CTRL      8'h00
`define SBD_ADDR_FMT       8'h04
`define SBD_ADDR_STAT      8'h08
`define SBD_ADDR_IRQ_STAT  8'h0C
`define SBD_ADDR_IRQ_MASK  8'h10

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SBD_BIT_MST        5
`define SBD_BIT_DIR        4
`define SBD_BIT_ACK_CHECK_ENABLE       3
`define SBD_BIT_FMT_A      0
`define SBD_BIT_FMT_B      1
`define SBD_BIT_ACKF       0
`define SBD_BIT_HALT       1
`define SBD_IRQ_ARB        0
`define SBD_IRQ_ACK        1
`define SBD_IRQ_SLV_TX     2
`define SBD_IRQ_W          3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define SBD_RST_DIR        1'b0
`define SBD_RST_MST        1'b0
`define SBD_RST_ACK_CHECK_ENABLE       1'b0
`define SBD_RST_FMT        1'b0
`define SBD_RST_IRQ        3'h0

`endif

// ### rtl/sbd_pkg.sv
// types shared by the serial bus direction and acknowledge control block
// assumes nothing of its surroundings
package sbd_pkg;

  // deferral state of a software direction write
  typedef enum logic [1:0] {
    SBD_WR_IDLE = 2'b01,
    SBD_WR_HELD = 2'b10
  } sbd_wr_e;

  typedef logic [7:0] sbd_addr_t;
  typedef logic [2:0] sbd_irq_t;

endpackage

// ### rtl/sbd_sticky.sv
// sticky event bits, write-one-to-clear, with mask and level interrupt
// assumes events and writes come from logic on the same clock
`timescale 1ns/100ps
`include "sbd_params.svh"

module sbd_sticky (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire sbd_pkg::sbd_irq_t event_set,
  input  wire logic             clear_wr,
  input  wire sbd_pkg::sbd_irq_t clear_data,
  input  wire logic             mask_wr,
  input  wire sbd_pkg::sbd_irq_t mask_data,
  output sbd_pkg::sbd_irq_t     status,
  output sbd_pkg::sbd_irq_t     mask,
  output logic                  irq
);

  // ----------------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------------
  wire sbd_pkg::sbd_irq_t clear_bits  = clear_wr ? clear_data : `SBD_RST_IRQ;
  // set wins over a clear landing in the same cycle, so no event is lost
  wire sbd_pkg::sbd_irq_t next_status = event_set | (status & ~clear_bits);
  wire sbd_pkg::sbd_irq_t next_mask   = mask_wr ? mask_data : mask;

  // irq follows the next values so it stays a plain flop output
  always_ff @(posedge clk) begin
    if (reset) begin
      status <= `SBD_RST_IRQ;
      mask   <= `SBD_RST_IRQ;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      mask   <= next_mask;
      irq    <= |(next_status & next_mask);
    end
  end

endmodule

// ### testbench/i2c_direction_ack_control_bench.sv
// self-checking bench of the direction and acknowledge control block
// assumes the apb slave answers with one wait state, bus engine modelled
`timescale 1ns/100ps
`include "sbd_params.svh"

module i2c_direction_ack_control_bench;
  // ------------------------------------------------------------------
  // signals and instances
  // ------------------------------------------------------------------
  logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic        frame_active, arb_lost, rw_strobe, rw_bit, ack_strobe, ack_bit;
  logic        start_detect, direction_select, master_select, ack_check_enable;
  logic        ack_status_flag, transfer_halt;
  int          n_mismatch = 0;
  int          total_checks = 0;
  localparam logic [7:0] a_ctl = `SBD_ADDR_CTRL;
  localparam logic [7:0] a_fmt = `SBD_ADDR_FMT;
  localparam logic [7:0] a_st = `SBD_ADDR_STAT;
  localparam logic [7:0] a_is = `SBD_ADDR_IRQ_STAT;
  localparam logic [7:0] a_im = `SBD_ADDR_IRQ_MASK;

  sbd_dir_ack sbd_dir_ack_inst (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .frame_active, .arb_lost, .rw_strobe,
    .rw_bit, .ack_strobe, .ack_bit, .start_detect, .direction_select,
    .master_select, .ack_check_enable, .ack_status_flag, .transfer_halt, .irq);
  sbd_bus_model sbd_bus_model_inst (.clk, .frame_active, .arb_lost, .rw_strobe,
    .rw_bit, .ack_strobe, .ack_bit, .start_detect);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] ctl(input logic m, input logic t, input logic a);
    return {26'h0, m, t, a, 3'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer; waits on pready, extra edge lets outputs settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge clk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge clk) penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 8'h00, 32'h0};
    void'($urandom(32'h089D263C));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rdc("ctrl", a_ctl, 32'h0);
    rdc("stat", a_st, 32'h0);
    apb(1'b1, a_im, 32'h7);
    // random control words, no hardware events so no lock applies
    repeat (8) begin
      d = $urandom;
      apb(1'b1, a_ctl, d);
      chk("dir", direction_select, d[4]);
      chk("ack_check_enable", ack_check_enable, d[3]);
      rdc("ctrl", a_ctl, d & 32'h38);
    end
    apb(1'b0, 8'hFC, 32'h0);
    chk("slverr", er, 1'b1);
    chk("rdata", rd, 32'h0);
    // arbitration loss as master transmitter, then the read-first lock
    apb(1'b1, a_ctl, ctl(1, 1, 0));
    sbd_bus_model_inst.lose();
    chk("dir", direction_select, 1'b0);
    chk("mst", master_select, 1'b0);
    chk("irq", irq, 1'b1);
    apb(1'b1, a_ctl, ctl(1, 1, 0));
    chk("dir", direction_select, 1'b0);
    chk("mst", master_select, 1'b0);
    rdc("ctrl", a_ctl, 32'h0);
    apb(1'b1, a_ctl, ctl(1, 1, 0));
    chk("dir", direction_select, 1'b1);
    chk("mst", master_select, 1'b1);
    rdc("istat", a_is, 32'h1);
    apb(1'b1, a_is, 32'h1);
    chk("irq", irq, 1'b0);
    // slave first frame: format gate, set, then read-first clear
    apb(1'b1, a_ctl, 32'h0);
    apb(1'b1, a_fmt, 32'h3);
    rdc("fmt", a_fmt, 32'h3);
    sbd_bus_model_inst.first(1'b1);
    chk("dir", direction_select, 1'b0);
    apb(1'b1, a_fmt, 32'h1);
    sbd_bus_model_inst.first(1'b1);
    chk("dir", direction_select, 1'b1);
    apb(1'b1, a_ctl, 32'h0);
    chk("dir", direction_select, 1'b1);
    rdc("ctrl", a_ctl, ctl(0, 1, 0));
    apb(1'b1, a_ctl, 32'h0);
    chk("dir", direction_select, 1'b0);
    rdc("istat", a_is, 32'h4);
    apb(1'b1, a_is, 32'h4);
    // write during a frame waits until the acknowledge has passed
    fork
      sbd_bus_model_inst.ack(1'b0, $urandom_range(12, 9));
      begin
        repeat (2) @(posedge clk);
        apb(1'b1, a_ctl, ctl(0, 1, 0));
        chk("dir", direction_select, 1'b0);
      end
    join
    @(posedge clk);
    chk("dir", direction_select, 1'b1);
    // acknowledge check off, then on with ack and nack
    apb(1'b1, a_ctl, 32'h0);
    sbd_bus_model_inst.ack(1'b1, 2);
    rdc("stat", a_st, 32'h0);
    apb(1'b1, a_im, 32'h0);
    apb(1'b1, a_ctl, ctl(0, 0, 1));
    sbd_bus_model_inst.ack(1'b0, 2);
    rdc("stat", a_st, 32'h0);
    sbd_bus_model_inst.ack(1'b1, $urandom_range(6, 1));
    rdc("stat", a_st, 32'h3);
    chk("ackf", ack_status_flag, 1'b1);
    chk("halt", transfer_halt, 1'b1);
    chk("irq", irq, 1'b0);
    apb(1'b1, a_im, 32'h7);
    chk("irq", irq, 1'b1);
    sbd_bus_model_inst.start();
    chk("halt", transfer_halt, 1'b0);
    apb(1'b1, a_is, 32'h2);
    chk("irq", irq, 1'b0);
    // a good acknowledge overwrites the captured nack, then check off clears it
    sbd_bus_model_inst.ack(1'b0, 3);
    chk("ackf", ack_status_flag, 1'b0);
    sbd_bus_model_inst.ack(1'b1, 1);
    chk("ackf", ack_status_flag, 1'b1);
    apb(1'b1, a_ctl, 32'h0);
    chk("ack_check_enable", ack_check_enable, 1'b0);
    rdc("stat", a_st, 32'h0);
    final_report();
  end
endmodule

// ### testbench/sbd_bus_model.sv
// bus engine model: frames, arbitration loss, first frame and acknowledges
// assumes the bench calls one task at a time, except a frame beside apb
`timescale 1ns/100ps

module sbd_bus_model (
  input  wire logic clk,
  output logic      frame_active,
  output logic      arb_lost,
  output logic      rw_strobe,
  output logic      rw_bit,
  output logic      ack_strobe,
  output logic      ack_bit,
  output logic      start_detect
);
  // ------------------------------------------------------------------
  // event tasks; each ends one edge after its strobe so outputs settle
  // ------------------------------------------------------------------
  initial begin
    {frame_active, arb_lost, rw_strobe, rw_bit} = 4'h0;
    {ack_strobe, ack_bit, start_detect} = 3'h0;
  end
  // one-cycle pulse of a lost arbitration
  task automatic lose();
    @(posedge clk) arb_lost <= 1'b1;
    @(posedge clk) arb_lost <= 1'b0;
    @(posedge clk);
  endtask
  // start condition pulse
  task automatic start();
    @(posedge clk) start_detect <= 1'b1;
    @(posedge clk) start_detect <= 1'b0;
    @(posedge clk);
  endtask
  // first frame r/w bit; data line inverted after so stale values never pass
  task automatic first(input logic v);
    @(posedge clk) {rw_strobe, rw_bit} <= {1'b1, v};
    @(posedge clk) {rw_strobe, rw_bit} <= {1'b0, ~v};
    @(posedge clk);
  endtask
  // whole frame, slow or prompt, acknowledge strobed at its end
  task automatic ack(input logic v, input int slow);
    @(posedge clk) frame_active <= 1'b1;
    repeat (slow) @(posedge clk);
    {ack_strobe, ack_bit} <= {1'b1, v};
    @(posedge clk) {ack_strobe, ack_bit, frame_active} <= {1'b0, ~v, 1'b0};
    @(posedge clk);
  endtask
endmodule
